// ==== inc/vtp_pkg.sv ====
// Purpose: shared constants for the vector table placement controller
// Assumes: 16K-word program flash, word addresses 14 bits wide
// Notes: fuse and lock inputs are programmed when low
package vtp_pkg;

  localparam int unsigned FLASH_AW = 14;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // printed offset is not word aligned, so it is kept as an index
  localparam logic [ADDR_W-1:0] CORE_CTRL_IDX = 32'h0000_0035;
  localparam logic [ADDR_W-1:0] CORE_CTRL_ADDR = {CORE_CTRL_IDX[ADDR_W-3:0], 2'b00};

  localparam int unsigned UNLOCK_BIT = 0;
  localparam int unsigned SELECT_BIT = 1;
  localparam logic [REG_W-1:0] CORE_CTRL_RESET = 8'h00;

  localparam logic [3:0] UNLOCK_CYCLES = 4'h4;
  localparam logic [3:0] UNLOCK_LOAD = UNLOCK_CYCLES - 4'h1;

  localparam logic [FLASH_AW-1:0] FLASH_START = 14'h0000;
  localparam logic [FLASH_AW-1:0] VEC_FIRST_OFS = 14'h0002;
  localparam int unsigned VEC_STRIDE_SHIFT = 1;
  localparam logic [4:0] IRQ_NUM_LAST = 5'h19;

  localparam logic [1:0] BOOT_SIZE_4K = 2'h0;
  localparam logic [1:0] BOOT_SIZE_2K = 2'h1;
  localparam logic [1:0] BOOT_SIZE_1K = 2'h2;
  localparam logic [1:0] BOOT_SIZE_512 = 2'h3;
  localparam logic [FLASH_AW-1:0] BOOT_START_4K = 14'h3800;
  localparam logic [FLASH_AW-1:0] BOOT_START_2K = 14'h3c00;
  localparam logic [FLASH_AW-1:0] BOOT_START_1K = 14'h3e00;
  localparam logic [FLASH_AW-1:0] BOOT_START_512 = 14'h3f00;

  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  function automatic logic [FLASH_AW-1:0] vtp_boot_start(input logic [1:0] size_code);
    logic [FLASH_AW-1:0] start;
    start = BOOT_START_2K;
    unique case (size_code)
      BOOT_SIZE_4K: start = BOOT_START_4K;
      BOOT_SIZE_2K: start = BOOT_START_2K;
      BOOT_SIZE_1K: start = BOOT_START_1K;
      BOOT_SIZE_512: start = BOOT_START_512;
    endcase
    return start;
  endfunction

endpackage

// ==== src/vtp_pin_sync.sv ====
// Purpose: three-stage synchroniser for slow static pin levels
// Assumes: inputs change rarely (fuses, lock bits)
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps
module vtp_pin_sync
  import vtp_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
      stage3_ff <= RESET_VAL;
    end else if (clk_en) begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // only agreeing bits move, so a glitch lasting one sample never counts
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          level_ff[b] <= RESET_VAL[b];
        end else if (clk_en && (stage2_ff[b] == stage3_ff[b])) begin
          level_ff[b] <= stage3_ff[b];
        end
      end
    end
  endgenerate

  assign level_out = level_ff;

endmodule

// ==== src/vtp_ahb_slave.sv ====
// Purpose: AHB-Lite slave front end for the single control register
// Assumes: one slave on the bus, so hready equals our hreadyout
// Notes: zero wait states while clk_en is high; unmapped reads give zero
`timescale 1ns/100ps
module vtp_ahb_slave
  import vtp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [DATA_W-1:0] hrdata,
  input wire logic [REG_W-1:0] reg_rdata,
  output logic reg_wr,
  output logic [REG_W-1:0] reg_wdata
);

  logic wr_pend_ff;
  logic [DATA_W-1:0] hrdata_ff;
  logic addr_hit;

  assign addr_hit = hsel && hready && clk_en && (htrans == HTRANS_NONSEQ)
                    && (haddr == CORE_CTRL_ADDR) && (hsize == HSIZE_WORD);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_ff <= 1'b0;
    end else if (clk_en) begin
      wr_pend_ff <= addr_hit && hwrite;
    end
  end

  // read data is latched at the address phase, so it stands for the data phase
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_ff <= '0;
    end else if (clk_en) begin
      hrdata_ff <= (addr_hit && !hwrite) ? {{(DATA_W-REG_W){1'b0}}, reg_rdata} : '0;
    end
  end

  // a frozen clock enable stretches the data phase instead of losing it
  assign hreadyout = clk_en;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_ff;
  assign reg_wr = wr_pend_ff && clk_en;
  assign reg_wdata = hwdata[REG_W-1:0];

endmodule

// ==== src/vtp_ctrl.sv ====
// Purpose: places reset entry and interrupt vector table in program flash
// Assumes: core supplies a retire pulse per finished instruction and the
//   section it executes from; fuse and lock pins are static, low = programmed
// Notes: the register is reached over AHB-Lite as one aligned word
// Contract
// - With the select bit clear, vectors are fetched from the start of flash.
// - With the select bit set, vectors move to the boot section start chosen by the size fuses.
// - Boot reset fuse unprogrammed, 2K boot section, select set: reset at 0x0000, vectors 0x3C02 to 0x3C32, two words apart.
// - Boot reset fuse programmed, 2K boot section, select set: reset at 0x3C00, vectors from 0x3C02.
// - Boot reset fuse programmed with a 2K section: execution after reset starts at the boot section; reset entry stays 0x0000 until the fuses synchronise.
// - A new select value is taken only while the unlock bit is set; otherwise writes leave it unchanged.
// - Hardware clears the unlock bit four cycles after it was set, or earlier when select is written.
// - Interrupts are blocked from the cycle unlock is set until the instruction after the select write completes.
// - Without a select write, interrupts stay blocked four cycles and then resume.
// - The automatic blocking never changes the global interrupt enable flag.
// - Vectors in boot section and app-side lock programmed: interrupts blocked while executing the application.
// - Vectors in application and boot-side lock programmed: interrupts blocked while executing the boot section.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
module vtp_ctrl
  import vtp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [DATA_W-1:0] hrdata,
  input wire logic boot_reset_fuse_n,
  input wire logic [1:0] boot_size_fuse,
  input wire logic app_side_lock_bit_n,
  input wire logic boot_side_lock_bit_n,
  input wire logic exec_in_boot,
  input wire logic instr_retire,
  input wire logic global_irq_en,
  input wire logic [4:0] irq_num,
  output logic [FLASH_AW-1:0] reset_entry_addr,
  output logic [FLASH_AW-1:0] vector_table_base,
  output logic [FLASH_AW-1:0] vector_addr,
  output logic irq_change_block,
  output logic irq_service_en
);

  typedef enum logic [1:0] {
    VTP_IDLE = 2'b00,
    VTP_UNLOCKED = 2'b01,
    VTP_DRAIN = 2'b10
  } vtp_phase_e;

  logic reg_wr;
  logic [REG_W-1:0] reg_wdata;
  logic [REG_W-1:0] reg_rdata;
  logic [4:0] fuse_raw;
  logic [4:0] fuse_sync;
  logic boot_reset_n_s;
  logic [1:0] boot_size_s;
  logic app_lock_n_s;
  logic boot_lock_n_s;
  logic [FLASH_AW-1:0] boot_start;

  logic vector_table_select_ff;
  logic vector_change_unlock_ff;
  logic [3:0] unlock_cnt_ff;
  logic post_write_ff;
  vtp_phase_e phase_ff;
  logic [FLASH_AW-1:0] reset_entry_ff;
  logic [FLASH_AW-1:0] vector_base_ff;
  logic [FLASH_AW-1:0] vector_addr_ff;

  logic wr_unlock;
  logic wr_select;
  logic unlock_expire;
  logic lock_block;
  logic [FLASH_AW-1:0] nxt_vector_base;
  logic [FLASH_AW-1:0] nxt_vector_addr;
  logic [FLASH_AW-1:0] irq_ofs;

  vtp_ahb_slave u_bus (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .reg_rdata(reg_rdata),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata)
  );

  assign fuse_raw = {boot_side_lock_bit_n, app_side_lock_bit_n, boot_size_fuse,
                     boot_reset_fuse_n};

  // reset value is all unprogrammed so nothing locks before the pins settle
  vtp_pin_sync #(.WIDTH(5), .RESET_VAL(5'h1f)) u_fuse_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pin_in(fuse_raw),
    .level_out(fuse_sync)
  );

  assign boot_reset_n_s = fuse_sync[0];
  assign boot_size_s = fuse_sync[2:1];
  assign app_lock_n_s = fuse_sync[3];
  assign boot_lock_n_s = fuse_sync[4];
  assign boot_start = vtp_boot_start(boot_size_s);

  // register view: only the two placement bits exist, the rest read zero
  always_comb begin
    reg_rdata = CORE_CTRL_RESET;
    reg_rdata[SELECT_BIT] = vector_table_select_ff;
    reg_rdata[UNLOCK_BIT] = vector_change_unlock_ff;
  end

  assign wr_unlock = reg_wr && reg_wdata[UNLOCK_BIT];
  assign wr_select = reg_wr && !reg_wdata[UNLOCK_BIT] && vector_change_unlock_ff;
  assign unlock_expire = vector_change_unlock_ff && (unlock_cnt_ff == 4'h0);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vector_table_select_ff <= CORE_CTRL_RESET[SELECT_BIT];
    end else if (clk_en && wr_select) begin
      vector_table_select_ff <= reg_wdata[SELECT_BIT];
    end
  end

  // a fresh unlock write in the expiry cycle re-arms: set wins over clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vector_change_unlock_ff <= CORE_CTRL_RESET[UNLOCK_BIT];
      unlock_cnt_ff <= 4'h0;
    end else if (clk_en) begin
      if (wr_unlock) begin
        vector_change_unlock_ff <= 1'b1;
        unlock_cnt_ff <= UNLOCK_LOAD;
      end else if (wr_select || unlock_expire) begin
        vector_change_unlock_ff <= 1'b0;
        unlock_cnt_ff <= 4'h0;
      end else if (vector_change_unlock_ff) begin
        unlock_cnt_ff <= unlock_cnt_ff - 4'h1;
      end
    end
  end

  // the instruction after the select write must retire before servicing resumes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      post_write_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_select) begin
        post_write_ff <= 1'b1;
      end else if (instr_retire) begin
        post_write_ff <= 1'b0;
      end
    end
  end

  // phase tracker, readable in simulation and used by the covers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= VTP_IDLE;
    end else if (clk_en) begin
      unique case (phase_ff)
        VTP_IDLE: begin
          if (wr_unlock) begin
            phase_ff <= VTP_UNLOCKED;
          end
        end
        VTP_UNLOCKED: begin
          if (wr_unlock) begin
            phase_ff <= VTP_UNLOCKED;
          end else if (wr_select) begin
            phase_ff <= VTP_DRAIN;
          end else if (unlock_expire) begin
            phase_ff <= VTP_IDLE;
          end
        end
        VTP_DRAIN: begin
          if (wr_unlock) begin
            phase_ff <= VTP_UNLOCKED;
          end else if (instr_retire) begin
            phase_ff <= VTP_IDLE;
          end
        end
        default: phase_ff <= VTP_IDLE;
      endcase
    end
  end

  assign irq_change_block = vector_change_unlock_ff || post_write_ff;

  // lock bits only block when the table and the running code sit apart
  assign lock_block = (vector_table_select_ff && !app_lock_n_s && !exec_in_boot)
                      || (!vector_table_select_ff && !boot_lock_n_s && exec_in_boot);

  // the global enable is only read, never written back
  assign irq_service_en = global_irq_en && !irq_change_block && !lock_block;

  assign nxt_vector_base = vector_table_select_ff ? boot_start : FLASH_START;
  assign irq_ofs = {{(FLASH_AW-5){1'b0}}, irq_num} << VEC_STRIDE_SHIFT;
  assign nxt_vector_addr = nxt_vector_base + irq_ofs;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vector_base_ff <= FLASH_START;
      vector_addr_ff <= FLASH_START;
    end else if (clk_en) begin
      vector_base_ff <= nxt_vector_base;
      vector_addr_ff <= nxt_vector_addr;
    end
  end

  // reset entry follows the boot reset and boot size fuses alone, not the select bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_entry_ff <= FLASH_START;
    end else if (clk_en) begin
      reset_entry_ff <= boot_reset_n_s ? FLASH_START : boot_start;
    end
  end

  assign reset_entry_addr = reset_entry_ff;
  assign vector_table_base = vector_base_ff;
  assign vector_addr = vector_addr_ff;

  // checks
  localparam logic [FLASH_AW-1:0] CHK_FIRST_2K = 14'h3c02;
  localparam logic [FLASH_AW-1:0] CHK_LAST_2K = 14'h3c32;
  localparam logic [FLASH_AW-1:0] CHK_RESET_2K = 14'h3c00;

  logic [3:0] unlock_run_ff;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_run_ff <= 4'h0;
    end else if (clk_en) begin
      if (wr_unlock) begin
        unlock_run_ff <= 4'h1;
      end else if (vector_change_unlock_ff && !wr_select && !unlock_expire) begin
        unlock_run_ff <= unlock_run_ff + 4'h1;
      end else begin
        unlock_run_ff <= 4'h0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_base_flash_start: assert property (
    clk_en && !vector_table_select_ff |=> vector_table_base == FLASH_START)
    else $error("vector base not at flash start while select is clear");

  a_base_boot_start: assert property (
    clk_en && vector_table_select_ff |=> vector_table_base == $past(boot_start))
    else $error("vector base not at boot start while select is set");

  a_last_vec_2k: assert property (
    clk_en && vector_table_select_ff && boot_size_s == BOOT_SIZE_2K && boot_reset_n_s
    && irq_num == IRQ_NUM_LAST |=> vector_addr == CHK_LAST_2K && reset_entry_addr == FLASH_START)
    else $error("last vector or reset entry wrong for 2K boot section");

  a_reset_boot_2k: assert property (
    clk_en && vector_table_select_ff && boot_size_s == BOOT_SIZE_2K && !boot_reset_n_s
    |=> reset_entry_addr == CHK_RESET_2K && vector_table_base + VEC_FIRST_OFS == CHK_FIRST_2K)
    else $error("reset entry or first vector wrong with boot reset programmed");

  a_reset_follows_fuse: assert property (
    clk_en && !boot_reset_n_s |=> reset_entry_addr == $past(boot_start))
    else $error("reset entry not at boot start with fuse programmed");

  a_select_locked: assert property (
    !vector_change_unlock_ff |=> $stable(vector_table_select_ff))
    else $error("select bit changed without unlock");

  a_unlock_expires: assert property (
    unlock_run_ff <= UNLOCK_CYCLES)
    else $error("unlock bit held longer than four cycles");

  a_unlock_clear_sel: assert property (
    clk_en && wr_select |=> !vector_change_unlock_ff && post_write_ff)
    else $error("unlock not cleared by select write");

  a_block_during_seq: assert property (
    (vector_change_unlock_ff || post_write_ff) |-> !irq_service_en)
    else $error("interrupt serviced during vector change");

  a_release_timeout: assert property (
    clk_en && unlock_expire && !wr_unlock && !wr_select && !post_write_ff
    |=> !irq_change_block)
    else $error("block not released after unlock timeout");

  a_gie_respected: assert property (
    !irq_change_block && !lock_block |-> irq_service_en == global_irq_en)
    else $error("service enable differs from global enable outside blocking");

  a_app_lock_block: assert property (
    vector_table_select_ff && !app_lock_n_s && !exec_in_boot |-> !irq_service_en)
    else $error("interrupt serviced in application with app lock");

  a_boot_lock_block: assert property (
    !vector_table_select_ff && !boot_lock_n_s && exec_in_boot |-> !irq_service_en)
    else $error("interrupt serviced in boot section with boot lock");

  a_reserved_zero: assert property (
    hrdata[DATA_W-1:SELECT_BIT+1] == '0)
    else $error("reserved read bits not zero");

  c_select_moved: cover property (phase_ff == VTP_UNLOCKED ##1 phase_ff == VTP_DRAIN);
  c_unlock_timeout: cover property (clk_en && unlock_expire && !wr_select && !wr_unlock);
  c_lock_block: cover property (lock_block && global_irq_en);
  c_drain_done: cover property (phase_ff == VTP_DRAIN ##1 phase_ff == VTP_IDLE);

endmodule

// ==== verification/vector_table_placement_ctrl_bench.sv ====
// Purpose: self-checking bench for the vector table placement controller
// Assumes: single AHB-Lite slave, so hready is looped back from hreadyout
// Notes: the design carries its own assertions, so this bench only drives and compares
`timescale 1ns/100ps
module vector_table_placement_ctrl_bench
  import vtp_pkg::*;
;
  localparam int TIMEOUT_CYCLES = 5000;
  logic sys_clk, arst_n, clk_en, hsel, hwrite, instr_retire, global_irq_en;
  logic boot_reset_fuse_n, app_side_lock_bit_n, boot_side_lock_bit_n, exec_in_boot;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans, boot_size_fuse;
  logic [2:0] hsize;
  logic [DATA_W-1:0] hwdata, rd;
  logic [4:0] irq_num;
  wire logic hreadyout, hresp, irq_change_block, irq_service_en;
  wire logic [DATA_W-1:0] hrdata;
  wire logic [FLASH_AW-1:0] reset_entry_addr, vector_table_base, vector_addr;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  // transfer size used by the bus tasks; only a whole word reaches the register
  logic [2:0] bus_size = HSIZE_WORD;
  logic [FLASH_AW-1:0] boot_starts [4] = '{BOOT_START_4K, BOOT_START_2K, BOOT_START_1K,
    BOOT_START_512};

  vtp_ctrl dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .boot_reset_fuse_n(boot_reset_fuse_n), .boot_size_fuse(boot_size_fuse),
    .app_side_lock_bit_n(app_side_lock_bit_n), .boot_side_lock_bit_n(boot_side_lock_bit_n),
    .exec_in_boot(exec_in_boot), .instr_retire(instr_retire), .global_irq_en(global_irq_en),
    .irq_num(irq_num), .reset_entry_addr(reset_entry_addr),
    .vector_table_base(vector_table_base), .vector_addr(vector_addr),
    .irq_change_block(irq_change_block), .irq_service_en(irq_service_en));

  always #2 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hang is cut short here and counted as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // entered just after a clock edge; returns at the edge that ends the data phase
  task automatic ahb_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b1;
    hsize <= bus_size;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask

  task automatic ahb_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b0;
    hsize <= bus_size;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= HTRANS_IDLE;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic t_reset_state();
    ahb_read(CORE_CTRL_ADDR, rd);
    chk(rd, 32'h0000_0000, "register after reset");
    chk(32'(vector_table_base), 32'(FLASH_START), "table base after reset");
    irq_num <= 5'h03;
    wait_cyc(2);
    chk(32'(vector_addr), 32'(FLASH_START + 14'h0006), "vector three in flash");
    chk(32'(hresp), 32'(HRESP_OKAY), "response code");
    clk_en <= 1'b0;
    wait_cyc(1);
    chk(32'(hreadyout), 32'h0, "ready while clock disabled");
    clk_en <= 1'b1;
  endtask

  task automatic t_locked_write();
    ahb_write(CORE_CTRL_ADDR, 32'h0000_0002);
    ahb_read(CORE_CTRL_ADDR, rd);
    chk(rd, 32'h0000_0000, "select taken without unlock");
    ahb_write(CORE_CTRL_ADDR, 32'hffff_fffc);
    ahb_read(CORE_CTRL_ADDR, rd);
    chk(rd, 32'h0000_0000, "reserved bits stored");
    ahb_write(CORE_CTRL_ADDR + 32'h4, 32'h0000_0001);
    #1;
    chk(32'(irq_change_block), 32'h0, "unmapped write armed unlock");
    ahb_read(CORE_CTRL_ADDR + 32'h4, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    bus_size = 3'h0;
    ahb_write(CORE_CTRL_ADDR, 32'h0000_0001);
    #1;
    chk(32'(irq_change_block), 32'h0, "byte-size write armed unlock");
    bus_size = HSIZE_WORD;
  endtask

  task automatic t_move_vectors(input logic sel);
    ahb_write(CORE_CTRL_ADDR, 32'h0000_0001);
    #1;
    chk(32'(irq_change_block), 32'h1, "block after unlock");
    chk(32'(irq_service_en), 32'h0, "service during unlock");
    // second write lands two edges after the unlock, inside the four-cycle window
    ahb_write(CORE_CTRL_ADDR, {30'h0, sel, 1'b0});
    ahb_read(CORE_CTRL_ADDR, rd);
    chk(rd, {30'h0, sel, 1'b0}, "select after unlock, unlock cleared");
    chk(32'(irq_change_block), 32'h1, "block before next retire");
    instr_retire <= 1'b1;
    @(posedge sys_clk);
    instr_retire <= 1'b0;
    #1;
    chk(32'(irq_change_block), 32'h0, "block after retire");
    chk(32'(irq_service_en), 32'h1, "service resumes, global flag intact");
  endtask

  task automatic t_boot_vectors();
    wait_cyc(2);
    chk(32'(vector_table_base), 32'(BOOT_START_2K), "table base in boot");
    chk(32'(reset_entry_addr), 32'h0, "reset entry with fuse unprogrammed");
    irq_num <= 5'h01;
    wait_cyc(2);
    chk(32'(vector_addr), 32'h0000_3c02, "first vector in boot");
    irq_num <= IRQ_NUM_LAST;
    wait_cyc(2);
    chk(32'(vector_addr), 32'h0000_3c32, "last vector in boot");
  endtask

  task automatic t_boot_fuses();
    boot_reset_fuse_n <= 1'b0;
    irq_num <= 5'h01;
    for (int sz = 0; sz < 4; sz++) begin
      boot_size_fuse <= 2'(sz);
      wait_cyc(8);
      chk(32'(reset_entry_addr), 32'(boot_starts[sz]), "reset entry per size");
      chk(32'(vector_table_base), 32'(boot_starts[sz]), "table base per size");
      chk(32'(vector_addr), 32'(boot_starts[sz] + 14'h0002), "first vector per size");
    end
    boot_size_fuse <= BOOT_SIZE_2K;
    wait_cyc(8);
    chk(32'(reset_entry_addr), 32'h0000_3c00, "reset entry at 2K");
    boot_reset_fuse_n <= 1'b1;
    wait_cyc(8);
  endtask

  task automatic t_lock_blocking();
    app_side_lock_bit_n <= 1'b0;
    exec_in_boot <= 1'b0;
    wait_cyc(8);
    chk(32'(irq_service_en), 32'h0, "service in app, app lock set");
    exec_in_boot <= 1'b1;
    wait_cyc(1);
    chk(32'(irq_service_en), 32'h1, "service in boot, app lock set");
    app_side_lock_bit_n <= 1'b1;
    wait_cyc(8);
    t_move_vectors(1'b0);
    boot_side_lock_bit_n <= 1'b0;
    wait_cyc(8);
    chk(32'(irq_service_en), 32'h0, "service in boot, boot lock set");
    exec_in_boot <= 1'b0;
    wait_cyc(1);
    chk(32'(irq_service_en), 32'h1, "service in app, boot lock set");
    global_irq_en <= 1'b0;
    wait_cyc(1);
    chk(32'(irq_service_en), 32'h0, "service with global flag clear");
    global_irq_en <= 1'b1;
  endtask

  task automatic t_unlock_expiry();
    ahb_write(CORE_CTRL_ADDR, 32'h0000_0001);
    #1;
    chk(32'(irq_change_block), 32'h1, "block in first cycle");
    for (int i = 0; i < 3; i++) begin
      wait_cyc(1);
      chk(32'(irq_change_block), 32'h1, "block within four cycles");
    end
    wait_cyc(1);
    chk(32'(irq_change_block), 32'h0, "block after four cycles");
    chk(32'(irq_service_en), 32'h1, "service after expiry");
    ahb_read(CORE_CTRL_ADDR, rd);
    chk(rd, 32'h0000_0000, "unlock cleared by expiry");
    ahb_write(CORE_CTRL_ADDR, 32'h0000_0002);
    ahb_read(CORE_CTRL_ADDR, rd);
    chk(rd, 32'h0000_0000, "late select write ignored");
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = '0;
    boot_reset_fuse_n = 1'b1;
    boot_size_fuse = BOOT_SIZE_2K;
    app_side_lock_bit_n = 1'b1;
    boot_side_lock_bit_n = 1'b1;
    exec_in_boot = 1'b0;
    instr_retire = 1'b0;
    global_irq_en = 1'b1;
    irq_num = 5'h00;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    wait_cyc(8);
    t_reset_state();
    t_locked_write();
    t_move_vectors(1'b1);
    t_boot_vectors();
    t_boot_fuses();
    t_lock_blocking();
    t_unlock_expiry();
    report_and_stop();
  end
endmodule
